// ---- design/led_sink_shift_latch_detect.sv ----
// Purpose: Shift chain, output latch and LED fault detection with AXI4-Lite registers
// Assumes: All pins asynchronous to aclk; shift clock slow enough to sample
// Notes: Fault word reloads the shift chain on each strobe
//
// What this block does
// [RQ1] Sixteen channels, each from one latch bit
// [RQ2] Blank high forces every channel off
// [RQ3] Shift clock rise shifts serial input in
// [RQ4] Strobe rise copies shift chain to latch
// [RQ5] Detect select high selects short detection
// [RQ6] Detect select low selects open detection
// [RQ7] Detect select edge starts smart detection
// [RQ8] Real-time and smart detection styles supported
// [RQ9] Result valid after 0.1us of drive
// [RQ10] Fault bits return through serial stream
// [RQ11] Alarm pulled low on fault or overheat
// [RQ12] Strap high: serial out on falling edge
// [RQ13] Strap low: serial out on rising edge
// [RQ14] Serial out shows last chain stage
// [RQ15] Controller shifts sixteen bits per strobe
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "led_sink_map.svh"

module led_sink_shift_latch_detect
  import led_sink_pkg::*;
#(
  parameter int N = `CH_NUM,
  parameter int ADDR_W = `ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic data_strobe_in,
  input wire logic output_blank,
  input wire logic detect_select,
  input wire logic shift_edge_select,
  input wire logic [N-1:0] open_sense,
  input wire logic [N-1:0] short_sense,
  input wire logic over_temp,
  input wire logic alarm_in,
  output logic [N-1:0] led_sink_channels,
  output logic serial_out,
  output logic alarm_out,
  output logic alarm_oe,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SW = 2 * N + 8;
  localparam logic [SW-1:0] SYNC_RST = {{(SW-4){1'b0}}, 4'h8};
  localparam det_cnt_t TDET_CYC = det_cnt_t'((`TDET_NS + `CLK_NS - 1) / `CLK_NS);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return (a >> 2) == ADDR_W'(off >> 2);
  endfunction : reg_hit

  // ----------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------
  logic [SW-1:0] syn;
  logic sck_s, sdi_s, stb_s, blank_s, os_s, strap_s, ot_s, alarm_s;
  logic [N-1:0] open_s, short_s;
  logic sck_q, stb_q, os_q, ot_q;
  logic sck_rise, sck_fall, strobe_rise, os_edge, ot_rise;

  pin_sync #(.W(SW), .RST_VAL(SYNC_RST)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({alarm_in, over_temp, short_sense, open_sense, shift_edge_select,
        detect_select, output_blank, data_strobe_in, serial_in, shift_clock}),
    .q(syn)
  );

  assign {alarm_s, ot_s, short_s, open_s, strap_s, os_s, blank_s, stb_s, sdi_s, sck_s} = syn;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 1'b0;
      stb_q <= 1'b0;
      os_q <= 1'b0;
      ot_q <= 1'b0;
    end else begin
      sck_q <= sck_s;
      stb_q <= stb_s;
      os_q <= os_s;
      ot_q <= ot_s;
    end
  end

  assign sck_rise = sck_s && !sck_q;
  assign sck_fall = !sck_s && sck_q;
  assign strobe_rise = stb_s && !stb_q;
  assign os_edge = os_s != os_q; // RQ7
  assign ot_rise = ot_s && !ot_q;

  // ----------------------------------------
  // Shift chain, latch and channels
  // ----------------------------------------
  logic [N-1:0] shreg_q, latch_q, fault_q;
  logic [1:0] ctrl_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_q <= '0;
    end else if (strobe_rise) begin
      shreg_q <= fault_q; // RQ10
    end else if (sck_rise) begin
      shreg_q <= {shreg_q[N-2:0], sdi_s}; // RQ3
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out <= 1'b0;
    end else if (strobe_rise) begin
      serial_out <= fault_q[N-1]; // RQ14
    end else if (sck_rise && !strap_s) begin
      serial_out <= shreg_q[N-2]; // RQ13
    end else if (sck_fall && strap_s) begin
      serial_out <= shreg_q[N-1]; // RQ12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= '0;
    end else if (strobe_rise) begin
      latch_q <= shreg_q; // RQ4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_sink_channels <= '0;
    end else if (blank_s || ctrl_q[`CTRL_BLANK]) begin
      led_sink_channels <= '0; // RQ2
    end else begin
      led_sink_channels <= latch_q; // RQ1
    end
  end

  // ----------------------------------------
  // Detection response timers
  // ----------------------------------------
  logic [N-1:0] det_ok;

  for (genvar i = 0; i < N; i++) begin : g_det
    det_cnt_t cnt_q;
    always_ff @(posedge aclk) begin
      if (!aresetn || !led_sink_channels[i]) begin
        cnt_q <= '0;
      end else if (cnt_q != TDET_CYC) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
    assign det_ok[i] = cnt_q == TDET_CYC; // RQ9
  end

  // ----------------------------------------
  // Detection mode control
  // ----------------------------------------
  det_state_t st_q;
  det_cnt_t wait_q;
  logic smart_done, fault_any_q;

  assign smart_done = st_q == ST_SMART_WAIT && wait_q == TDET_CYC - 3'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_STATIC;
      wait_q <= '0;
    end else begin
      wait_q <= (st_q == ST_SMART_WAIT) ? wait_q + 3'h1 : 3'h0;
      case (st_q)
        ST_STATIC: begin
          if (os_edge) begin
            st_q <= ST_SMART_WAIT; // RQ7
          end
        end
        ST_SMART_WAIT: begin
          if (smart_done) begin
            st_q <= ST_SMART_HOLD; // RQ8
          end
        end
        ST_SMART_HOLD: begin
          if (os_edge) begin
            st_q <= ST_SMART_WAIT;
          end else if (strobe_rise) begin
            st_q <= ST_STATIC;
          end
        end
        default: begin
          st_q <= ST_STATIC;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= '0;
    end else if (st_q == ST_STATIC && !os_edge) begin
      fault_q <= (os_s ? short_s : open_s) & det_ok; // RQ5 RQ6 RQ8
    end else if (smart_done) begin
      fault_q <= (open_s | short_s) & det_ok; // RQ8
    end
  end

  // ----------------------------------------
  // Alarm pin
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_out <= 1'b0;
      alarm_oe <= 1'b0;
      fault_any_q <= 1'b0;
    end else begin
      alarm_out <= 1'b0;
      alarm_oe <= (|fault_q) || ot_s || ctrl_q[`CTRL_ALARM_FORCE]; // RQ11
      fault_any_q <= |fault_q;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [`IRQ_W-1:0] sts_q, mask_q, ev;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_do;

  assign ev = {smart_done, strobe_rise, ot_rise, (|fault_q) && !fault_any_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
    end else if (wr_do && reg_hit(awaddr_q, `OFF_IRQ_STS) && wstrb_q[0]) begin
      sts_q <= (sts_q & ~wdata_q[`IRQ_W-1:0]) | ev;
    end else begin
      sts_q <= sts_q | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_q & mask_q);
    end
  end

  // ----------------------------------------
  // AXI4-Lite write
  // ----------------------------------------
  logic wr_map;

  assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_map = reg_hit(awaddr_q, `OFF_CTRL) || reg_hit(awaddr_q, `OFF_STATUS)
    || reg_hit(awaddr_q, `OFF_FAULT) || reg_hit(awaddr_q, `OFF_IRQ_STS)
    || reg_hit(awaddr_q, `OFF_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_do) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_do) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RST;
      mask_q <= `MASK_RST;
    end else if (wr_do && wstrb_q[0]) begin
      if (reg_hit(awaddr_q, `OFF_CTRL)) begin
        ctrl_q <= wdata_q[1:0];
      end
      if (reg_hit(awaddr_q, `OFF_IRQ_MASK)) begin
        mask_q <= wdata_q[`IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= '0;
      if (reg_hit(s_axi_araddr, `OFF_CTRL)) begin
        s_axi_rdata <= {30'h0, ctrl_q};
      end else if (reg_hit(s_axi_araddr, `OFF_STATUS)) begin
        s_axi_rdata <= {11'h0, strap_s, alarm_s, ot_s, st_q, latch_q};
      end else if (reg_hit(s_axi_araddr, `OFF_FAULT)) begin
        s_axi_rdata <= {led_sink_channels, fault_q};
      end else if (reg_hit(s_axi_araddr, `OFF_IRQ_STS)) begin
        s_axi_rdata <= {28'h0, sts_q};
      end else if (reg_hit(s_axi_araddr, `OFF_IRQ_MASK)) begin
        s_axi_rdata <= {28'h0, mask_q};
      end else begin
        s_axi_rresp <= `RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_smart_enter;
    os_edge && st_q != ST_SMART_WAIT;
  endsequence
  sequence s_smart_leave;
    ##[1:6] st_q == ST_SMART_HOLD;
  endsequence

  property p_blank;
    blank_s |=> led_sink_channels == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("Channel on while blanked"); // RQ2

  property p_follow;
    !blank_s && !ctrl_q[`CTRL_BLANK] |=> led_sink_channels == $past(latch_q);
  endproperty
  a_follow: assert property (p_follow) else $error("Channel not from latch"); // RQ1

  property p_shift;
    sck_rise && !strobe_rise |=> shreg_q == {$past(shreg_q[N-2:0]), $past(sdi_s)};
  endproperty
  a_shift: assert property (p_shift) else $error("Shift chain missed bit"); // RQ3

  property p_latch;
    strobe_rise |=> latch_q == $past(shreg_q) && shreg_q == $past(fault_q);
  endproperty
  a_latch: assert property (p_latch) else $error("Strobe transfer wrong"); // RQ4

  property p_hold;
    !strobe_rise |=> $stable(latch_q);
  endproperty
  a_hold: assert property (p_hold) else $error("Latch changed without strobe"); // RQ4

  property p_short;
    st_q == ST_STATIC && !os_edge && os_s |=> fault_q == $past(short_s & det_ok);
  endproperty
  a_short: assert property (p_short) else $error("Short mode result wrong"); // RQ5

  property p_open;
    st_q == ST_STATIC && !os_edge && !os_s |=> fault_q == $past(open_s & det_ok);
  endproperty
  a_open: assert property (p_open) else $error("Open mode result wrong"); // RQ6

  property p_smart;
    s_smart_enter |=> st_q == ST_SMART_WAIT ##0 s_smart_leave;
  endproperty
  a_smart: assert property (p_smart) else $error("Smart detection sequence wrong"); // RQ7

  property p_valid;
    $rose(led_sink_channels[0]) |=> !det_ok[0] [*4] ##1 det_ok[0] || !led_sink_channels[0];
  endproperty
  a_valid: assert property (p_valid) else $error("Detect timer length wrong"); // RQ9

  property p_alarm;
    (|fault_q) || ot_s |=> alarm_oe && !alarm_out;
  endproperty
  a_alarm: assert property (p_alarm) else $error("Alarm not driven"); // RQ11

  property p_fall_out;
    sck_fall && strap_s && !strobe_rise |=> serial_out == $past(shreg_q[N-1]);
  endproperty
  a_fall_out: assert property (p_fall_out) else $error("Falling edge output wrong"); // RQ12

  property p_rise_out;
    sck_rise && !strap_s && !strobe_rise |=> serial_out == shreg_q[N-1];
  endproperty
  a_rise_out: assert property (p_rise_out) else $error("Rising edge output wrong"); // RQ13

  property p_irq;
    ##1 irq == |($past(sts_q) & $past(mask_q));
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt level wrong");

endmodule : led_sink_shift_latch_detect

`default_nettype wire

// ---- design/led_sink_map.svh ----
// Purpose: Offsets, field positions, reset values and timing in ns
// Assumes: 32-bit AXI4-Lite register words, 50 MHz aclk
// Notes: Definitions only
`ifndef LED_SINK_MAP_SVH
`define LED_SINK_MAP_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define CH_NUM 16
`define ADDR_W 8

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_FAULT 8'h08
`define OFF_IRQ_STS 8'h0C
`define OFF_IRQ_MASK 8'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_BLANK 0
`define CTRL_ALARM_FORCE 1
`define CTRL_RST 2'h0
`define IRQ_FAULT 0
`define IRQ_OTEMP 1
`define IRQ_LATCH 2
`define IRQ_SMART 3
`define IRQ_W 4
`define MASK_RST 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 20
`define TDET_NS 100

`endif

// ---- design/led_sink_pkg.sv ----
// Purpose: Types shared by the LED sink block
// Assumes: Constants live in led_sink_map.svh
// Notes: Types only
package led_sink_pkg;

  typedef enum logic [1:0] {
    ST_STATIC = 2'b00,
    ST_SMART_WAIT = 2'b01,
    ST_SMART_HOLD = 2'b10
  } det_state_t;

  typedef logic [2:0] det_cnt_t;

endpackage : led_sink_pkg

// ---- design/pin_sync.sv ----
// Purpose: Two-flop synchroniser for a bundle of pin levels
// Assumes: Inputs asynchronous to aclk
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= RST_VAL;
    end else begin
      meta_q <= d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_VAL;
    end else begin
      q <= meta_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ---- bench/led_ctrl_model.sv ----
// Purpose: Display controller driving the serial shift chain
// Assumes: Link clock period 160 ns, held low between frames
// Notes: Callers start off the aclk edge; bit leads clock rise by 80 - PH
`timescale 1ns/1ps
`default_nettype none

module led_ctrl_model #(
  parameter int PH = 7
) (
  output logic shift_clock,
  output logic serial_in,
  output logic data_strobe_in
);
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    data_strobe_in = 1'b0;
  end

  // ----------------------------------------
  // Pin sequences
  // ----------------------------------------
  task automatic rise(input logic b);
    #(PH) serial_in = b;
    #(80 - PH) shift_clock = 1'b1;
  endtask : rise

  task automatic fall();
    #80 shift_clock = 1'b0;
    // Hold time over, line no longer shows the bit
    serial_in = ~serial_in;
  endtask : fall

  task automatic send(input logic [15:0] w, input int n);
    for (int i = 15; i > 15 - n; i--) begin
      rise(w[i]);
      fall();
    end
  endtask : send

  task automatic strobe();
    #(PH) data_strobe_in = 1'b1;
    #80 data_strobe_in = 1'b0;
  endtask : strobe
endmodule : led_ctrl_model

`default_nettype wire

// ---- bench/led_sink_shift_latch_detect_tb_top.sv ----
// Purpose: Self-checking bench for the LED sink block
// Assumes: Controller model drives the link pins
// Notes: Expected results queued, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "led_sink_map.svh"

module led_sink_shift_latch_detect_tb_top import led_sink_pkg::*;;
  typedef struct {int k; logic [33:0] v;} note_t;
  logic aclk = 1'b0, aresetn = 1'b0, output_blank = 1'b0, detect_select = 1'b0;
  logic shift_clock, serial_in, data_strobe_in, shift_edge_select = 1'b0, over_temp = 1'b0;
  logic [15:0] open_sense = '0, short_sense = '0, led_sink_channels, w, o, s;
  logic serial_out, alarm_out, alarm_oe, irq, chk = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wire alarm_in = alarm_oe ? alarm_out : 1'b1;
  wire [3:0] pv = {irq, alarm_oe, serial_out, 1'b0};
  int fails = 0, comparisons = 0, ck = 0;
  note_t q[$];
  string nm[6] = '{"channels", "serial_out", "alarm_oe", "irq", "rdata", "bresp"};

  always #10 aclk = ~aclk;

  led_ctrl_model ctrl (.shift_clock(shift_clock), .serial_in(serial_in),
    .data_strobe_in(data_strobe_in));

  led_sink_shift_latch_detect dut (.aclk(aclk), .aresetn(aresetn),
    .shift_clock(shift_clock), .serial_in(serial_in), .data_strobe_in(data_strobe_in),
    .output_blank(output_blank), .detect_select(detect_select),
    .shift_edge_select(shift_edge_select), .open_sense(open_sense),
    .short_sense(short_sense), .over_temp(over_temp), .alarm_in(alarm_in),
    .led_sink_channels(led_sink_channels), .serial_out(serial_out),
    .alarm_out(alarm_out), .alarm_oe(alarm_oe), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  function automatic void take(int k, logic [33:0] seen);
    note_t n;
    n.k = -1;
    n.v = 'x;
    if (q.size() > 0) n = q.pop_front();
    comparisons++;
    if (n.k != k || n.v !== seen) begin
      fails++;
      $display("BAD %s exp %h got %h", nm[k], n.v, seen);
    end
  endfunction : take

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) take(5, {32'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) take(4, {s_axi_rresp, s_axi_rdata});
    if (chk) take(ck, ck == 0 ? {18'h0, led_sink_channels} : {33'h0, pv[ck]});
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic pin(int k, logic [33:0] v);
    repeat (6) @(posedge aclk);
    q.push_back('{k, v});
    chk <= 1'b1;
    ck <= k;
    @(posedge aclk);
    chk <= 1'b0;
  endtask : pin

  task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    @(posedge aclk);
    q.push_back('{5, {32'h0, r}});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(logic [7:0] a, logic [33:0] v);
    @(posedge aclk);
    q.push_back('{4, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic frame(logic [15:0] d, logic st);
    @(posedge aclk);
    shift_edge_select <= st;
    #7 ctrl.send(d, 15);
    ctrl.rise(d[0]);
    pin(1, {33'h0, !st});
    #7 ctrl.fall();
    if (st) pin(1, 34'h1);
    ctrl.strobe();
    pin(0, {18'h0, d});
  endtask : frame

  task automatic end_sim();
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_sim();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(61562));
    w = 16'($urandom()) | 16'hC001;
    o = (16'($urandom()) | 16'h8001) & 16'hBFFF;
    s = 16'($urandom());
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`OFF_CTRL, {`RESP_OKAY, 32'h0});
    axr(`OFF_IRQ_MASK, {`RESP_OKAY, 28'h0, `MASK_RST});
    axr(8'h40, {`RESP_SLVERR, 32'h0});
    axw(8'h40, 32'hFFFFFFFF, `RESP_SLVERR);
    frame(w, 1'b0);
    axr(`OFF_STATUS, {`RESP_OKAY, 32'h00080000 | w});
    output_blank <= 1'b1;
    pin(0, 34'h0);
    output_blank <= 1'b0;
    pin(0, {18'h0, w});
    axw(`OFF_CTRL, 32'h1, `RESP_OKAY);
    pin(0, 34'h0);
    axw(`OFF_CTRL, 32'h0, `RESP_OKAY);
    frame(w, 1'b1);
    open_sense <= o;
    short_sense <= s;
    pin(2, 34'h1);
    axr(`OFF_FAULT, {`RESP_OKAY, w, w & o});
    frame(w, 1'b0);
    pin(1, 34'h1);
    #7 ctrl.rise(1'b0);
    ctrl.fall();
    pin(1, 34'h0);
    detect_select <= 1'b1;
    repeat (12) @(posedge aclk);
    axr(`OFF_FAULT, {`RESP_OKAY, w, w & (o | s)});
    frame(w, 1'b0);
    axr(`OFF_FAULT, {`RESP_OKAY, w, w & s});
    pin(3, 34'h0);
    axw(`OFF_IRQ_MASK, 32'h4, `RESP_OKAY);
    pin(3, 34'h1);
    axw(`OFF_IRQ_STS, 32'hF, `RESP_OKAY);
    pin(3, 34'h0);
    open_sense <= '0;
    short_sense <= '0;
    pin(2, 34'h0);
    axw(`OFF_CTRL, 32'h2, `RESP_OKAY);
    pin(2, 34'h1);
    axw(`OFF_CTRL, 32'h0, `RESP_OKAY);
    over_temp <= 1'b1;
    pin(2, 34'h1);
    axr(`OFF_STATUS, {`RESP_OKAY, 32'h00040000 | w});
    axr(`OFF_IRQ_STS, {`RESP_OKAY, 32'h2});
    end_sim();
  end
endmodule : led_sink_shift_latch_detect_tb_top

`default_nettype wire
